//--- mrp_pkg.sv
// Package: register map, field layout, reset values and timing constants of the PHY port
package mrp_pkg;
  // System clock and management clock limits
  localparam int unsigned CLK_KHZ            = 10000;
  localparam int unsigned MDC_MAX_KHZ        = 1670;
  localparam int unsigned MDC_HALF_CYC       = (CLK_KHZ + 2 * MDC_MAX_KHZ - 1) / (2 * MDC_MAX_KHZ);
  // Reference clock decimation at 10Mbps in RMII
  localparam int unsigned RMII_DECIM         = 10;
  // Management frame layout
  localparam int unsigned MDIO_FRAME_BITS    = 64;
  localparam int unsigned MDIO_RD_DRIVE_BITS = 46;
  localparam int unsigned MDIO_DATA_FIRST    = 48;
  localparam logic [1:0]  MDIO_ST            = 2'h1;
  localparam logic [1:0]  MDIO_OP_RD         = 2'h2;
  localparam logic [1:0]  MDIO_OP_WR         = 2'h1;
  localparam logic [1:0]  MDIO_TA_WR         = 2'h2;
  // Register byte addresses
  localparam logic [7:0]  ADDR_CTRL          = 8'h00;
  localparam logic [7:0]  ADDR_TXDATA        = 8'h04;
  localparam logic [7:0]  ADDR_RXDATA        = 8'h08;
  localparam logic [7:0]  ADDR_STATUS        = 8'h0C;
  localparam logic [7:0]  ADDR_MDIOCMD       = 8'h10;
  localparam logic [7:0]  ADDR_MDIORD        = 8'h14;
  // Field positions
  localparam int unsigned TXD_LAST           = 8;
  localparam int unsigned CMD_PHY_LSB        = 5;
  localparam int unsigned CMD_WR             = 10;
  localparam int unsigned CMD_WDATA_LSB      = 16;
  localparam int unsigned ST_FLAG_LSB        = 8;
  // Sticky flag indexes inside the status flag field
  localparam int unsigned FLG_RXVAL          = 0;
  localparam int unsigned FLG_RXOVR          = 1;
  localparam int unsigned FLG_RXEND          = 2;
  localparam int unsigned FLG_RXERR          = 3;
  localparam int unsigned FLG_COL            = 4;
  localparam int unsigned FLG_UNDER          = 5;
  localparam int unsigned FLG_N              = 6;

  typedef struct packed {
    logic fullDuplex;
    logic dce;
    logic speed100;
    logic rmii;
  } mrp_cfg_t;

  typedef struct packed {
    logic [15:0] wdata;
    logic        write;
    logic [4:0]  phy;
    logic [4:0]  regAddr;
  } mrp_mdio_cmd_t;

  localparam mrp_cfg_t CFG_RESET = 4'h2;
endpackage : mrp_pkg

//--- mrp_sync.sv
// Two-flop synchroniser with rising-edge detect on the synchronised value
`timescale 1ns/1ps
`default_nettype none
module mrp_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic [W-1:0]      dout,
  output logic [W-1:0]      rise
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  // Only the second stage reads the first
  always_ff @(posedge clock) begin
    if (srst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign dout = sync_ff;
  assign rise = sync_ff & ~prev_ff;
endmodule : mrp_sync
`default_nettype wire

//--- mrp_mdio_master.sv
// Management frame engine: divided clock, 64-bit read/write frames on a shared data line
`timescale 1ns/1ps
`default_nettype none
module mrp_mdio_master (
  input  wire logic                   clock,
  input  wire logic                   srst,
  input  wire logic                   start,
  input  wire mrp_pkg::mrp_mdio_cmd_t cmd,
  input  wire logic                   mdioIn,
  output logic                        busy,
  output logic [15:0]                 rdata,
  output logic                        mdc,
  output logic                        mdioOut,
  output logic                        mdioOe
);
  import mrp_pkg::*;

  if (MDC_HALF_CYC < 1 || MDC_HALF_CYC > 16) begin : g_chk
    $error("MDC_HALF_CYC out of range");
  end

  typedef enum logic {MDIO_IDLE, MDIO_RUN} mrp_mdio_st_t;
  mrp_mdio_st_t st_ff, nxt_st;
  logic [3:0]   div_ff, nxt_div;
  logic         mdc_ff, nxt_mdc;
  logic [5:0]   bit_ff, nxt_bit;
  logic [63:0]  sh_ff, nxt_sh;
  logic         wr_ff, nxt_wr;
  logic [15:0]  rd_ff, nxt_rd;
  logic         halfEnd;

  assign halfEnd = div_ff == 4'(MDC_HALF_CYC - 1);

  // Frame sequencing: drive on falling MDC, sample read data on rising MDC
  always_comb begin
    nxt_st  = st_ff;
    nxt_div = div_ff;
    nxt_mdc = mdc_ff;
    nxt_bit = bit_ff;
    nxt_sh  = sh_ff;
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    case (st_ff)
      MDIO_IDLE: begin
        if (start) begin
          nxt_st  = MDIO_RUN;
          nxt_div = 4'h0;
          nxt_mdc = 1'b0;
          nxt_bit = 6'h0;
          nxt_wr  = cmd.write;
          nxt_sh  = {32'hFFFFFFFF, MDIO_ST, cmd.write ? MDIO_OP_WR : MDIO_OP_RD,
                     cmd.phy, cmd.regAddr, MDIO_TA_WR, cmd.wdata};
        end
      end
      MDIO_RUN: begin
        nxt_div = halfEnd ? 4'h0 : div_ff + 4'h1;
        if (halfEnd) begin
          nxt_mdc = !mdc_ff;
          if (!mdc_ff && !wr_ff && bit_ff >= 6'(MDIO_DATA_FIRST)) begin
            nxt_rd = {rd_ff[14:0], mdioIn};
          end
          if (mdc_ff) begin
            nxt_sh  = {sh_ff[62:0], 1'b1};
            nxt_bit = bit_ff + 6'h1;
            if (bit_ff == 6'(MDIO_FRAME_BITS - 1)) begin
              nxt_st = MDIO_IDLE;
            end
          end
        end
      end
      default: nxt_st = MDIO_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clock) begin
    if (srst) begin
      st_ff  <= MDIO_IDLE;
      div_ff <= 4'h0;
      mdc_ff <= 1'b0;
      bit_ff <= 6'h0;
      sh_ff  <= 64'hFFFFFFFFFFFFFFFF;
      wr_ff  <= 1'b0;
      rd_ff  <= 16'h0;
    end else begin
      st_ff  <= nxt_st;
      div_ff <= nxt_div;
      mdc_ff <= nxt_mdc;
      bit_ff <= nxt_bit;
      sh_ff  <= nxt_sh;
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
    end
  end

  // Reads release the line from the turnaround onward
  assign busy    = st_ff == MDIO_RUN;
  assign mdc     = mdc_ff;
  assign mdioOut = sh_ff[63];
  assign mdioOe  = busy && (wr_ff || bit_ff < 6'(MDIO_RD_DRIVE_BITS));
  assign rdata   = rd_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  mdc_half_period_a: assert property ($changed(mdc) |=> $stable(mdc) [*2])
    else $error("MDC half period shorter than three clocks");
  mdio_rd_release_a: assert property ((busy && !wr_ff && bit_ff >= 6'(MDIO_RD_DRIVE_BITS)) |-> !mdioOe)
    else $error("MDIO driven during read turnaround or data");
endmodule : mrp_mdio_master
`default_nettype wire

//--- mrp_phy_port.sv
// Top level: MII/RMII PHY port with frame shifters, management master and APB registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - The MII transmit clock runs at 25MHz at 100Mbps and 2.5MHz at 10Mbps.
// - In DTE mode both MII clocks come from the PHY, in DCE mode the port drives them at a speed-dependent rate.
// - Receive data, data valid and error are sampled on the rising edge of the receive clock.
// - In MII mode transmit enable rises with the first preamble nibble on a rising transmit clock and stays high.
// - Transmit enable drops at the end of each frame before the next frame's first nibble.
// - The four transmit bits change on the rising transmit clock, bit 0 least significant, ignored while enable is low.
// - In RMII mode two transmit bits go out per reference tick with transmit enable marking them valid; at 10Mbps the code holds each dibit for ten ticks.
// - In MII mode four receive bits per receive clock are taken, bit 0 first, and dropped while data valid is low.
// - In RMII mode two bits are taken per reference tick at 100Mbps, once per ten ticks at 10Mbps, only with CRS_DV high.
// - The receive error input is counted only while carrier sense is high.
// - Collision is acted on only in half duplex and ignored in full duplex.
// - The management clock is divided from the system clock and never exceeds 1.67MHz.
// - Management reads and writes reach 32 registers in each of 32 PHYs.
// - Auto-negotiation can be started by a management register write.
// - In RMII mode all link signals are timed by the single reference clock.
module mrp_phy_port #(
  parameter int unsigned DCE_HALF_CYC = 1,
  parameter int unsigned DECIM        = mrp_pkg::RMII_DECIM
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        txClkIn,
  output logic             txClkOut,
  output logic             txClkOe,
  input  wire logic        rxClkIn,
  output logic             rxClkOut,
  output logic             rxClkOe,
  input  wire logic        refClk,
  output logic             txEn,
  output logic [3:0]       txd,
  input  wire logic [3:0]  rxd,
  input  wire logic        rxDv,
  input  wire logic        carrier_sense_in,
  input  wire logic        rxErr,
  input  wire logic        collision_in,
  output logic             mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOe
);
  import mrp_pkg::*;

  if (DCE_HALF_CYC < 1 || DCE_HALF_CYC > 25) begin : g_chk_dce
    $error("DCE_HALF_CYC out of range");
  end
  if (DECIM < 5 || DECIM > 15) begin : g_chk_dec
    $error("DECIM out of range");
  end

  // Unit extraction and shift for nibble or dibit lanes
  function automatic logic [3:0] unitOf(input logic [7:0] b, input logic r);
    unitOf = r ? {2'h0, b[1:0]} : b[3:0];
  endfunction : unitOf
  function automatic logic [7:0] shiftOf(input logic [7:0] b, input logic r);
    shiftOf = r ? {2'h0, b[7:2]} : {4'h0, b[7:4]};
  endfunction : shiftOf

  mrp_cfg_t      cfg_ff, nxt_cfg;
  logic [2:0]    clkS;
  logic [2:0]    clkRise;
  logic [8:0]    datS;
  logic [3:0]    rxdS;
  logic          rxDvS, crsS, rxErrS, colS, mdioS;
  logic [7:0]    dceCnt_ff, nxt_dceCnt;
  logic          dceClk_ff, nxt_dceClk;
  logic          dceEnd, dceRise;
  logic [3:0]    decCnt_ff, nxt_decCnt;
  logic          decOk, refTick, txTick, rxTick;
  logic [7:0]    hold_ff, nxt_hold, txSh_ff, nxt_txSh;
  logic          holdFull_ff, nxt_holdFull, holdLast_ff, nxt_holdLast;
  logic          txLast_ff, nxt_txLast, txEn_ff, nxt_txEn, txUnder;
  logic [1:0]    txRem_ff, nxt_txRem;
  logic [3:0]    txd_ff, nxt_txd;
  logic [7:0]    rxAcc_ff, nxt_rxAcc, rxByte_ff, nxt_rxByte, accIn;
  logic [1:0]    rxCnt_ff, nxt_rxCnt;
  logic          dvPrev_ff, nxt_dvPrev, rxDvSel, rxByteDone;
  logic [FLG_N-1:0] flag_ff, nxt_flag, flagSet, flagClr;
  mrp_mdio_cmd_t cmd_ff, nxt_cmd;
  logic          mdioBusy, mdioStart;
  logic [15:0]   mdioRdata;
  logic [31:0]   prdata_ff, nxt_prdata, rdVal;
  logic          setupPh, accPh, wrAcc, rdAcc, addrHit;

  // Pin inputs pass two flops before use
  mrp_sync #(.W(3)) u_clk_sync (
    .clock (clock),
    .srst  (srst),
    .din   ({refClk, rxClkIn, txClkIn}),
    .dout  (clkS),
    .rise  (clkRise)
  );
  mrp_sync #(.W(9)) u_dat_sync (
    .clock (clock),
    .srst  (srst),
    .din   ({mdioIn, collision_in, rxErr, carrier_sense_in, rxDv, rxd}),
    .dout  (datS),
    .rise  ()
  );
  assign {mdioS, colS, rxErrS, crsS, rxDvS, rxdS} = datS;

  // Management frame engine
  mrp_mdio_master u_mdio (
    .clock   (clock),
    .srst    (srst),
    .start   (mdioStart),
    .cmd     (nxt_cmd), // New command reaches the engine in its start cycle
    .mdioIn  (mdioS),
    .busy    (mdioBusy),
    .rdata   (mdioRdata),
    .mdc     (mdc),
    .mdioOut (mdioOut),
    .mdioOe  (mdioOe)
  );

  // DCE clock divider: half period stretched tenfold at 10Mbps
  assign dceEnd  = dceCnt_ff == (cfg_ff.speed100 ? 8'(DCE_HALF_CYC - 1) : 8'(DCE_HALF_CYC * 10 - 1));
  assign dceRise = dceEnd && !dceClk_ff;
  always_comb begin
    nxt_dceCnt = dceEnd ? 8'h00 : dceCnt_ff + 8'h01;
    nxt_dceClk = dceEnd ? !dceClk_ff : dceClk_ff;
  end

  // Reference tick decimation for RMII at 10Mbps
  assign decOk   = cfg_ff.speed100 || decCnt_ff == 4'h0;
  assign refTick = clkRise[2] && decOk;
  always_comb begin
    nxt_decCnt = decCnt_ff;
    if (clkRise[2]) begin
      nxt_decCnt = (decCnt_ff == 4'(DECIM - 1)) ? 4'h0 : decCnt_ff + 4'h1;
    end
  end

  // Link ticks: PHY clock edges in DTE, own divider in DCE, reference clock in RMII
  assign txTick = cfg_ff.rmii ? refTick : (cfg_ff.dce ? dceRise : clkRise[0]);
  assign rxTick = cfg_ff.rmii ? refTick : (cfg_ff.dce ? dceRise : clkRise[1]);

  // Transmit holder and nibble/dibit shifter
  always_comb begin
    nxt_hold     = hold_ff;
    nxt_holdFull = holdFull_ff;
    nxt_holdLast = holdLast_ff;
    nxt_txSh     = txSh_ff;
    nxt_txRem    = txRem_ff;
    nxt_txLast   = txLast_ff;
    nxt_txEn     = txEn_ff;
    nxt_txd      = txd_ff;
    txUnder      = 1'b0;
    if (wrAcc && paddr == ADDR_TXDATA && !holdFull_ff) begin
      nxt_hold     = pwdata[7:0];
      nxt_holdLast = pwdata[TXD_LAST];
      nxt_holdFull = 1'b1;
    end
    if (txTick) begin
      if (colS && !cfg_ff.fullDuplex && txEn_ff) begin
        nxt_txEn   = 1'b0;
        nxt_txd    = 4'h0;
        nxt_txRem  = 2'h0;
        nxt_txLast = 1'b0;
      end else if (txRem_ff != 2'h0) begin
        nxt_txd   = unitOf(txSh_ff, cfg_ff.rmii);
        nxt_txSh  = shiftOf(txSh_ff, cfg_ff.rmii);
        nxt_txRem = txRem_ff - 2'h1;
      end else if (holdFull_ff && !(txEn_ff && txLast_ff)) begin
        nxt_txd      = unitOf(hold_ff, cfg_ff.rmii);
        nxt_txSh     = shiftOf(hold_ff, cfg_ff.rmii);
        nxt_txRem    = cfg_ff.rmii ? 2'h3 : 2'h1;
        nxt_txLast   = holdLast_ff;
        nxt_holdFull = 1'b0;
        nxt_txEn     = 1'b1;
      end else begin
        txUnder    = txEn_ff && !txLast_ff;
        nxt_txEn   = 1'b0;
        nxt_txd    = 4'h0;
        nxt_txLast = 1'b0;
      end
    end
  end

  // Receive assembler, low lane first
  assign rxDvSel    = cfg_ff.rmii ? crsS : rxDvS;
  assign accIn      = cfg_ff.rmii ? {rxdS[1:0], rxAcc_ff[7:2]} : {rxdS, rxAcc_ff[7:4]};
  assign rxByteDone = rxTick && rxDvSel && rxCnt_ff == (cfg_ff.rmii ? 2'h3 : 2'h1);
  always_comb begin
    nxt_rxAcc  = rxAcc_ff;
    nxt_rxCnt  = rxCnt_ff;
    nxt_rxByte = rxByte_ff;
    nxt_dvPrev = dvPrev_ff;
    if (rxTick) begin
      nxt_dvPrev = rxDvSel;
      if (rxDvSel) begin
        nxt_rxAcc = accIn;
        nxt_rxCnt = rxByteDone ? 2'h0 : rxCnt_ff + 2'h1;
        if (rxByteDone) begin
          nxt_rxByte = accIn;
        end
      end else begin
        nxt_rxCnt = 2'h0;
      end
    end
  end

  // Sticky status flags: a set in the clearing cycle wins
  always_comb begin
    flagSet            = '0;
    flagSet[FLG_RXVAL] = rxByteDone;
    flagSet[FLG_RXOVR] = rxByteDone && flag_ff[FLG_RXVAL];
    flagSet[FLG_RXEND] = rxTick && !rxDvSel && dvPrev_ff;
    flagSet[FLG_RXERR] = rxTick && crsS && rxErrS;
    flagSet[FLG_COL]   = colS && !cfg_ff.fullDuplex && txEn_ff;
    flagSet[FLG_UNDER] = txUnder;
    flagClr            = '0;
    if (wrAcc && paddr == ADDR_STATUS) begin
      flagClr = pwdata[ST_FLAG_LSB +: FLG_N];
    end
    if (rdAcc && paddr == ADDR_RXDATA) begin
      flagClr[FLG_RXVAL] = 1'b1;
    end
    nxt_flag = (flag_ff & ~flagClr) | flagSet;
  end

  // APB phases; zero wait states
  assign setupPh   = psel && !penable;
  assign accPh     = psel && penable;
  assign wrAcc     = accPh && pwrite;
  assign rdAcc     = accPh && !pwrite;
  assign mdioStart = wrAcc && paddr == ADDR_MDIOCMD && !mdioBusy;

  // Read mux and address decode
  always_comb begin
    rdVal   = 32'h0;
    addrHit = 1'b1;
    case (paddr)
      ADDR_CTRL:    rdVal = {28'h0, cfg_ff};
      ADDR_TXDATA:  rdVal = {23'h0, holdLast_ff, hold_ff};
      ADDR_RXDATA:  rdVal = {24'h0, rxByte_ff};
      ADDR_STATUS:  rdVal = {18'h0, flag_ff, 5'h0, mdioBusy, txEn_ff, holdFull_ff};
      ADDR_MDIOCMD: rdVal = {cmd_ff.wdata, 5'h0, cmd_ff.write, cmd_ff.phy, cmd_ff.regAddr};
      ADDR_MDIORD:  rdVal = {16'h0, mdioRdata};
      default:      addrHit = 1'b0;
    endcase
  end

  // Register writes and read capture
  always_comb begin
    nxt_cfg    = cfg_ff;
    nxt_cmd    = cmd_ff;
    nxt_prdata = setupPh ? rdVal : prdata_ff;
    if (wrAcc && paddr == ADDR_CTRL) begin
      nxt_cfg = pwdata[3:0];
    end
    if (mdioStart) begin
      nxt_cmd = {pwdata[CMD_WDATA_LSB +: 16], pwdata[CMD_WR], pwdata[CMD_PHY_LSB +: 5], pwdata[4:0]};
    end
  end

  // Configuration, bus and flag registers
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_ff    <= CFG_RESET;
      cmd_ff    <= '0;
      prdata_ff <= 32'h0;
      flag_ff   <= '0;
      dceCnt_ff <= 8'h00;
      dceClk_ff <= 1'b0;
      decCnt_ff <= 4'h0;
    end else begin
      cfg_ff    <= nxt_cfg;
      cmd_ff    <= nxt_cmd;
      prdata_ff <= nxt_prdata;
      flag_ff   <= nxt_flag;
      dceCnt_ff <= nxt_dceCnt;
      dceClk_ff <= nxt_dceClk;
      decCnt_ff <= nxt_decCnt;
    end
  end

  // Transmit and receive registers
  always_ff @(posedge clock) begin
    if (srst) begin
      hold_ff     <= 8'h00;
      holdFull_ff <= 1'b0;
      holdLast_ff <= 1'b0;
      txSh_ff     <= 8'h00;
      txRem_ff    <= 2'h0;
      txLast_ff   <= 1'b0;
      txEn_ff     <= 1'b0;
      txd_ff      <= 4'h0;
      rxAcc_ff    <= 8'h00;
      rxCnt_ff    <= 2'h0;
      rxByte_ff   <= 8'h00;
      dvPrev_ff   <= 1'b0;
    end else begin
      hold_ff     <= nxt_hold;
      holdFull_ff <= nxt_holdFull;
      holdLast_ff <= nxt_holdLast;
      txSh_ff     <= nxt_txSh;
      txRem_ff    <= nxt_txRem;
      txLast_ff   <= nxt_txLast;
      txEn_ff     <= nxt_txEn;
      txd_ff      <= nxt_txd;
      rxAcc_ff    <= nxt_rxAcc;
      rxCnt_ff    <= nxt_rxCnt;
      rxByte_ff   <= nxt_rxByte;
      dvPrev_ff   <= nxt_dvPrev;
    end
  end

  // Outputs
  assign prdata   = prdata_ff;
  assign pready   = accPh;
  assign pslverr  = accPh && !addrHit;
  assign txEn     = txEn_ff;
  assign txd      = txd_ff;
  assign txClkOut = dceClk_ff;
  assign rxClkOut = dceClk_ff;
  assign txClkOe  = cfg_ff.dce && !cfg_ff.rmii;
  assign rxClkOe  = cfg_ff.dce && !cfg_ff.rmii;

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  txen_on_tick_a: assert property ($changed(txEn_ff) |-> $past(txTick))
    else $error("Transmit enable moved off a transmit tick");
  txd_on_tick_a: assert property (!txTick |=> $stable(txd_ff))
    else $error("Transmit data moved off a transmit tick");
  frame_gap_a: assert property ((txTick && txEn_ff && txLast_ff && txRem_ff == 2'h0) |=> !txEn_ff)
    else $error("Transmit enable not dropped after last byte");
  rmii10_tx_hold_a: assert property ((cfg_ff.rmii && !cfg_ff.speed100 && txTick) |=> !txTick [*8])
    else $error("RMII 10Mbps dibit held too briefly");
  rmii10_rx_rate_a: assert property ((cfg_ff.rmii && !cfg_ff.speed100 && rxTick) |=> !rxTick [*8])
    else $error("RMII 10Mbps receive sampled too often");
  rx_discard_a: assert property ($rose(flag_ff[FLG_RXVAL]) |-> $past(rxTick && rxDvSel))
    else $error("Receive byte completed without data valid");
  rx_err_gate_a: assert property ($rose(flag_ff[FLG_RXERR]) |-> $past(crsS && rxErrS))
    else $error("Receive error taken without carrier sense");
  col_full_duplex_a: assert property ($rose(flag_ff[FLG_COL]) |-> !$past(cfg_ff.fullDuplex))
    else $error("Collision acted on in full duplex");

  frame_end_c: cover property (txEn_ff ##1 !txEn_ff);
  rx_byte_c: cover property ($rose(flag_ff[FLG_RXVAL]));
  collision_c: cover property ($rose(flag_ff[FLG_COL]));
endmodule : mrp_phy_port
`default_nettype wire

//--- mrp_phy_model.sv
// PHY model: one slow MII clock, nibble capture on transmit, MII and RMII byte send on receive
`timescale 1ns/1ps
`default_nettype none
module mrp_phy_model (
  output logic             phyClk,
  input  wire logic        refClk,
  input  wire logic        txEn,
  input  wire logic [3:0]  txd,
  output logic [3:0]       rxd,
  output logic             rxDv,
  output logic             crs
);
  logic [7:0] txq[$];
  logic [3:0] lowNib;
  logic       half;

  // Idle pins and the shared transmit/receive clock, 1.25 MHz
  initial begin
    phyClk = 1'b0;
    rxd = 4'h5;
    rxDv = 1'b0;
    crs = 1'b0;
    half = 1'b0;
  end
  always #400 phyClk = ~phyClk;

  // Nibbles count only while enable is high, low nibble first
  always @(posedge phyClk) begin
    if (txEn === 1'b1) begin
      if (half) txq.push_back({txd, lowNib});
      else lowNib = txd;
      half = ~half;
    end else half = 1'b0;
  end

  // One byte, launched on the falling edge so rising edges see it settled
  task automatic send_byte(input logic [7:0] b);
    @(negedge phyClk);
    rxDv = 1'b1;
    crs = 1'b1;
    rxd = b[3:0];
    @(negedge phyClk);
    rxd = b[7:4];
    @(negedge phyClk);
    rxDv = 1'b0;
    crs = 1'b0;
    rxd = ~b[7:4];
  endtask : send_byte

  // RMII byte at 10Mbps: each dibit held ten reference clocks, carrier marks the data
  task automatic send_rmii(input logic [7:0] b);
    logic [7:0] s;
    s = b;
    for (int i = 0; i < 5; i++) begin
      @(negedge refClk);
      crs = i < 4;
      rxd = {2'h0, s[1:0]};
      s = s >> 2;
      repeat (9) @(negedge refClk);
    end
  endtask : send_rmii
endmodule : mrp_phy_model
`default_nettype wire

//--- testbench.sv
// Testbench for the PHY port: registers, frames both ways, management frames
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mrp_pkg::*;
  logic        clock, srst, psel, penable, pwrite, pready, pslverr, er;
  logic        phyClk, txEn, rxDv, crs, col, mdc, mdioOut, mdioOe, mdioW;
  logic [7:0]  paddr;
  logic [3:0]  txd, rxd;
  logic [31:0] pwdata, prdata, rd, frame;
  int          badCount, nCompared, mdcRise;
  logic        refClk, rxe, txOe, rxOe, txClkO, rxClkO;
  logic [7:0]  rmiiSh;
  int          rmiiN;

  mrp_phy_port mrp_phy_port_i (.clock, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .txClkIn(phyClk), .txClkOut(txClkO), .txClkOe(txOe), .rxClkIn(phyClk),
    .rxClkOut(rxClkO), .rxClkOe(rxOe), .refClk, .txEn, .txd, .rxd, .rxDv, .carrier_sense_in(crs),
    .rxErr(rxe), .collision_in(col), .mdc, .mdioIn(mdioW), .mdioOut, .mdioOe);
  mrp_phy_model mrp_phy_model_i (.phyClk, .refClk, .txEn, .txd, .rxd, .rxDv, .crs);

  // Free-running reference clock, 400 ns
  initial refClk = 1'b0;
  always #200 refClk = ~refClk;

  // RMII transmit: count enabled reference clocks, keep the first sample of every ten
  always @(posedge refClk) begin
    if (txEn === 1'b1) begin
      if (rmiiN % 10 == 0) rmiiSh <= {txd[1:0], rmiiSh[7:2]};
      rmiiN++;
    end
  end

  // Management line with its pull-up
  assign mdioW = mdioOe ? mdioOut : 1'b1;

  // System clock, 100 ns
  initial clock = 1'b0;
  always #50 clock = ~clock;

  // Count management clocks and shift the line in on their rising edge
  always @(posedge mdc) begin
    mdcRise++;
    frame <= {frame[30:0], mdioW};
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic poll(int b, logic v);
    do apb(1'b0, ADDR_STATUS, 32'h0); while (rd[b] !== v);
  endtask : poll

  task automatic t_regs;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", rd, {28'h0, CFG_RESET});
    apb(1'b0, 8'h3C, 32'h0);
    chk("pslverr", {31'h0, er}, 32'h1);
  endtask : t_regs

  // Two-byte frame with collision raised throughout
  task automatic t_tx(logic [31:0] cfg, logic flag);
    col <= 1'b1;
    apb(1'b1, ADDR_CTRL, cfg);
    mrp_phy_model_i.txq.delete();
    apb(1'b1, ADDR_TXDATA, 32'h5A);
    poll(0, 1'b0);
    apb(1'b1, ADDR_TXDATA, 32'h11C);
    poll(0, 1'b0);
    poll(1, 1'b0);
    chk("col flag", {31'h0, rd[ST_FLAG_LSB+FLG_COL]}, {31'h0, flag});
    if (!flag) begin
      chk("tx count", 32'(mrp_phy_model_i.txq.size()), 32'h2);
      chk("tx byte0", {24'h0, mrp_phy_model_i.txq[0]}, 32'h5A);
      chk("tx byte1", {24'h0, mrp_phy_model_i.txq[1]}, 32'h1C);
    end
    apb(1'b1, ADDR_STATUS, 32'h3F00);
    col <= 1'b0;
  endtask : t_tx

  task automatic t_rx;
    mrp_phy_model_i.send_byte(8'hBA);
    poll(ST_FLAG_LSB + FLG_RXVAL, 1'b1);
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk("rx byte", rd & 32'hFF, 32'hBA);
  endtask : t_rx

  // DCE mode at 10Mbps: both clock pins driven, period of twenty system clocks
  task automatic t_dce;
    time t0;
    apb(1'b1, ADDR_CTRL, 32'h4);
    @(posedge txClkO);
    t0 = $time;
    repeat (10) @(posedge txClkO);
    chk("tx clk period", 32'($time - t0), 32'd20000);
    @(posedge rxClkO);
    t0 = $time;
    repeat (10) @(posedge rxClkO);
    chk("rx clk period", 32'($time - t0), 32'd20000);
    chk("clk oe", {30'h0, rxOe, txOe}, 32'h3);
  endtask : t_dce

  // RMII 10Mbps: one byte each way, receive error gated by carrier
  task automatic t_rmii;
    rmiiN = 0;
    apb(1'b1, ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_TXDATA, 32'h1B4);
    poll(0, 1'b0);
    poll(1, 1'b0);
    chk("rmii tx units", rmiiN, 32'd40);
    chk("rmii tx byte", {24'h0, rmiiSh}, 32'hB4);
    rxe <= 1'b1;
    repeat (100) @(posedge clock);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("err no carrier", {31'h0, rd[ST_FLAG_LSB+FLG_RXERR]}, 32'h0);
    mrp_phy_model_i.send_rmii(8'h96);
    poll(ST_FLAG_LSB + FLG_RXVAL, 1'b1);
    chk("err carrier", {31'h0, rd[ST_FLAG_LSB+FLG_RXERR]}, 32'h1);
    rxe <= 1'b0;
    apb(1'b0, ADDR_RXDATA, 32'h0);
    chk("rmii rx byte", rd & 32'hFF, 32'h96);
  endtask : t_rmii

  task automatic t_mdio(logic [31:0] cmd, logic [31:0] exp, logic [31:0] rexp);
    mdcRise = 0;
    apb(1'b1, ADDR_MDIOCMD, cmd);
    poll(2, 1'b0);
    chk("mdc count", mdcRise, 32'd64);
    chk("mdio frame", frame, exp);
    apb(1'b0, ADDR_MDIORD, 32'h0);
    chk("mdio read", rd & 32'hFFFF, rexp);
  endtask : t_mdio

  task automatic final_report;
    if (badCount == 0 && nCompared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // Watchdog, well past the expected run
  initial begin
    #3000000;
    badCount++;
    final_report;
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    col = 1'b0;
    rxe = 1'b0;
    rmiiN = 0;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    t_regs;
    t_tx(32'hA, 1'b0);
    t_tx(32'h2, 1'b1);
    t_rx;
    t_dce;
    t_rmii;
    t_mdio(32'h3FF, 32'h6FFFFFFF, 32'hFFFF);
    t_mdio(32'h12000420, 32'h50821200, 32'hFFFF);
    final_report;
  end
endmodule : testbench
`default_nettype wire
